// >>> rtl/dbs_pkg.sv
// Behaviour
// - second beat address is base plus one, wrapping within the low two bits
// - read-select low requests a read
// - write-select low requests a write, high writes nothing
// - read and write machines run side by side
// - both machines take commands on positive clock rise and also step on the negative rise
// - same-kind command on adjacent rise is dropped
// - both selects low after idle: read wins
// - narrow width: two active-low lane masks per beat
// - wide width: four lane masks, all high aborts
// - reads return the newest written data
// - loop bypass cuts read latency by one cycle
package dbs_pkg;

    // array geometry
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int ADDR_W = 8;
    localparam int DEPTH = 256;

    // read latency counted in half-cycle strobes after the command strobe
    localparam int RD_HALF_NORMAL = 4;
    localparam int RD_HALF_BYPASS = 2;
    // pipeline slot index that is emitted after that many strobes
    localparam int SLOT_NORMAL = RD_HALF_NORMAL - 1;
    localparam int SLOT_BYPASS = RD_HALF_BYPASS - 1;
    localparam int PIPE_D = RD_HALF_NORMAL + 1;

    // lanes that exist in each width
    localparam logic [3:0] LANES_WIDE = 4'hf;
    localparam logic [3:0] LANES_NARROW = 4'h3;

    typedef logic [ADDR_W-1:0] dbs_addr_t;
    typedef logic [DATA_W-1:0] dbs_data_t;

    // one output slot of the read pipeline
    typedef struct packed {
        logic v;
        dbs_addr_t addr;
    } dbs_slot_s;

    // one masked write into the array
    typedef struct packed {
        logic en;
        dbs_addr_t addr;
        dbs_data_t data;
        logic [LANES-1:0] lane_en;
    } dbs_wport_s;

    // two-bit linear burst counter: low bits step, upper bits stay
    function automatic dbs_addr_t burst_next(input dbs_addr_t base);
        burst_next = {base[ADDR_W-1:2], base[1:0] + 2'h1};
    endfunction

    // active-low masks to lane enables, unused lanes forced off in narrow width
    function automatic logic [LANES-1:0] lane_enables(input logic [LANES-1:0] mask_n, input logic wide);
        lane_enables = ~mask_n & (wide ? LANES_WIDE : LANES_NARROW);
    endfunction

    // lay the enabled lanes of a new word over an old one
    function automatic dbs_data_t lane_merge(input dbs_data_t old_w, input dbs_data_t new_w,
                                             input logic [LANES-1:0] en);
        dbs_data_t r;
        r = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (en[i]) begin
                r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        lane_merge = r;
    endfunction

endpackage

// >>> rtl/dbs_mem.sv
// storage array with one lane-masked write port and one combinational read port
module dbs_mem (
    // clock
    input wire logic ref_clk,
    // write side
    input dbs_pkg::dbs_wport_s wport,
    // read side
    input dbs_pkg::dbs_addr_t rd_addr,
    output dbs_pkg::dbs_data_t rd_word
);

    // array contents are not reset: like the real cells they power up unknown
    dbs_pkg::dbs_data_t mem [dbs_pkg::DEPTH];

    // per-lane write so masked lanes keep their old contents
    always_ff @(posedge ref_clk) begin
        if (wport.en) begin
            for (int i = 0; i < dbs_pkg::LANES; i++) begin
                if (wport.lane_en[i]) begin
                    mem[wport.addr][i*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] <=
                        wport.data[i*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
                end
            end
        end
    end

    // read is combinational; the caller registers it
    assign rd_word = mem[rd_addr];

endmodule

// >>> rtl/dbs_top.sv
// command, burst and data-path control of the dual-port burst-of-two sram
module dbs_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // half-cycle strobes of the input clock pair
    input wire logic k_rise,
    input wire logic kn_rise,
    // command pins
    input wire logic read_sel_n,
    input wire logic write_sel_n,
    input dbs_pkg::dbs_addr_t rd_addr,
    input dbs_pkg::dbs_addr_t wr_addr,
    // write data and lane masks
    input dbs_pkg::dbs_data_t wr_data,
    input wire logic lane0_write_mask_n,
    input wire logic lane1_write_mask_n,
    input wire logic lane2_write_mask_n,
    input wire logic lane3_write_mask_n,
    // static straps
    input wire logic wide_mode,
    input wire logic dll_on_n,
    // read data pins
    output dbs_pkg::dbs_data_t rd_data,
    output logic rd_data_oe
);

    // whole state of the block
    typedef struct packed {
        logic rd_prev;                                 // read accepted at last positive rise
        logic wr_prev;                                 // write accepted at last positive rise
        logic nop_prev;                                // last positive rise was idle
        logic wr_pend;                                 // write waiting for its second beat
        dbs_pkg::dbs_addr_t wr_addr1;                  // address of that second beat
        dbs_pkg::dbs_slot_s [dbs_pkg::PIPE_D-1:0] pipe; // read beats in flight
        dbs_pkg::dbs_data_t dout;                      // output data register
        logic oe;                                      // output driven
    } dbs_state_s;

    dbs_state_s s_q;
    dbs_state_s s_d;
    dbs_pkg::dbs_wport_s wport;   // write issued this cycle
    dbs_pkg::dbs_data_t arr_word; // raw array word for the slot being emitted
    logic [dbs_pkg::LANES-1:0] mask_n;

    // masks gathered into one lane vector
    assign mask_n = {lane3_write_mask_n, lane2_write_mask_n, lane1_write_mask_n, lane0_write_mask_n};

    // storage; read always looks at the head of the read pipeline
    dbs_mem u_mem (
        .ref_clk(ref_clk),
        .wport(wport),
        .rd_addr(s_q.pipe[0].addr),
        .rd_word(arr_word)
    );

    // next-state logic for both machines
    always_comb begin
        logic rd_go;
        logic wr_go;
        logic [dbs_pkg::LANES-1:0] en;
        int slot;
        rd_go = 1'b0;
        wr_go = 1'b0;
        en = dbs_pkg::lane_enables(mask_n, wide_mode);
        slot = dll_on_n ? dbs_pkg::SLOT_NORMAL : dbs_pkg::SLOT_BYPASS;
        s_d = s_q;
        wport = '0;

        // write machine: first beat with the command, second on the negative rise
        if (k_rise) begin
            // a write right after an accepted write is dropped
            wr_go = !write_sel_n && !s_q.wr_prev;
            // both selects after an idle rise: the read wins, the write is dropped
            if (!read_sel_n && s_q.nop_prev) begin
                wr_go = 1'b0;
            end
            if (wr_go) begin
                // beat one lands at the base address on the positive rise
                wport = '{en: 1'b1, addr: wr_addr, data: wr_data, lane_en: en};
                s_d.wr_pend = 1'b1;
                s_d.wr_addr1 = dbs_pkg::burst_next(wr_addr);
            end
            s_d.wr_prev = wr_go;
        end else if (kn_rise && s_q.wr_pend) begin
            // beat two with masks sampled on the negative rise; all masks high aborts it
            wport = '{en: 1'b1, addr: s_q.wr_addr1, data: wr_data, lane_en: en};
            s_d.wr_pend = 1'b0;
        end

        // read pipeline advances on every half-cycle strobe
        if (k_rise || kn_rise) begin
            if (s_q.pipe[0].v) begin
                // newest data: a write in this very cycle is laid over the array word
                s_d.dout = (wport.en && wport.addr == s_q.pipe[0].addr) ?
                    dbs_pkg::lane_merge(arr_word, wport.data, wport.lane_en) : arr_word;
                s_d.oe = 1'b1;
            end else begin
                // empty slot: pins float, data register keeps its last value
                s_d.oe = 1'b0;
            end
            for (int i = 0; i < dbs_pkg::PIPE_D - 1; i++) begin
                s_d.pipe[i] = s_q.pipe[i+1];
            end
            s_d.pipe[dbs_pkg::PIPE_D-1] = '0;
        end

        // read machine, independent of the write machine
        if (k_rise) begin
            rd_go = !read_sel_n && !s_q.rd_prev;
            if (rd_go) begin
                // beats queued so they leave at t+2.0 and t+2.5 (one cycle less in bypass)
                s_d.pipe[slot] = '{v: 1'b1, addr: rd_addr};
                s_d.pipe[slot+1] = '{v: 1'b1, addr: dbs_pkg::burst_next(rd_addr)};
            end
            s_d.rd_prev = rd_go;
            s_d.nop_prev = read_sel_n && write_sel_n;
        end
    end

    // state register; with no strobes everything holds, which is clock stop
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // pins straight from the state register
    assign rd_data = s_q.dout;
    assign rd_data_oe = s_q.oe;

endmodule

// >>> verif/dbs_ctl_model.sv
// controller side: the input clock pair as strobes two ref_clk apart
module dbs_ctl_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // stop request, honoured only at a frame edge
    input wire logic run,
    // strobes
    output logic k_rise,
    output logic kn_rise
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_q; // phase within one input clock period
    logic en_q; // run latched per frame so kn never loses its k
    // strobe frame: k at phase 3, kn two cycles later
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {ph_q, en_q, k_rise, kn_rise} <= 5'h00;
        end else begin
            ph_q <= ph_q + 2'h1;
            en_q <= (ph_q == 2'h2) ? run : en_q; // clocks stand still between frames
            k_rise <= en_q && (ph_q == 2'h3);
            kn_rise <= en_q && (ph_q == 2'h1); // second beat half a period on
        end
    end
endmodule

// >>> verif/dbs_sva.sv
// watches the read pins against the strobes
module dbs_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // strobes and read command
    input wire logic k_rise,
    input wire logic kn_rise,
    input wire logic read_sel_n,
    input wire logic dll_on_n,
    // read pins
    input dbs_pkg::dbs_data_t rd_data,
    input wire logic rd_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // beat registered on the 4th strobe (8 clocks on; 2nd strobe, 4 clocks on, in bypass), seen on the pins one clock later
    logic rd_prev_q; // previous k strobe took a read
    wire rd_acc = k_rise && !read_sel_n && !rd_prev_q; // read that is not refused
    // history of acceptance, needed to spot adjacent reads
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_prev_q <= 1'b0;
        end else if (k_rise) begin
            rd_prev_q <= rd_acc;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_lat; rd_acc && dll_on_n |-> ##9 rd_data_oe ##2 rd_data_oe ##2 !rd_data_oe; endproperty
    a_lat: assert property (p_lat) else $error("read beats off slot");
    property p_byp; rd_acc && !dll_on_n |-> ##5 rd_data_oe ##2 rd_data_oe; endproperty
    a_byp: assert property (p_byp) else $error("bypass beats off slot");
    property p_edge; rd_data_oe != $past(rd_data_oe) |-> $past(k_rise || kn_rise); endproperty
    a_edge: assert property (p_edge) else $error("enable moved off strobe");
    property p_drop; k_rise && !read_sel_n && rd_prev_q |-> ##9 !rd_data_oe ##2 !rd_data_oe; endproperty
    a_drop: assert property (p_drop) else $error("adjacent read served");
    property p_nop; k_rise && read_sel_n && dll_on_n |-> ##9 !rd_data_oe; endproperty
    a_nop: assert property (p_nop) else $error("idle slot driven");
    property p_pair; $rose(rd_data_oe) |-> rd_data_oe [*4]; endproperty
    a_pair: assert property (p_pair) else $error("burst not two beats");
    property p_hold; !$past(k_rise || kn_rise) |-> $stable(rd_data); endproperty
    a_hold: assert property (p_hold) else $error("data moved without strobe");
    property p_rst; $fell(reset) |-> !rd_data_oe [*3]; endproperty
    a_rst: assert property (p_rst) else $error("driven after reset");
    c_rd: cover property (rd_acc && dll_on_n);
    c_byp: cover property (rd_acc && !dll_on_n);
    c_drop: cover property (k_rise && !read_sel_n && rd_prev_q);
endmodule

// >>> verif/ddr_burst2_sram_port_control_tb.sv
module ddr_burst2_sram_port_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // bench pins, changed on the rising edge
    logic ref_clk = 1'b0, reset = 1'b1, run = 1'b1, read_sel_n = 1'b1, write_sel_n = 1'b1;
    logic wide_mode = 1'b1, dll_on_n = 1'b1;
    logic [3:0] msk = 4'hf; // bit i masks lane i
    dbs_pkg::dbs_addr_t rd_addr = 8'h00, wr_addr = 8'h00;
    dbs_pkg::dbs_data_t wr_data = 36'h0, rd_data;
    logic k_rise, kn_rise, rd_data_oe, lane0_write_mask_n, lane1_write_mask_n, lane2_write_mask_n, lane3_write_mask_n;
    int miscompares = 0, compares = 0;
    assign {lane3_write_mask_n, lane2_write_mask_n, lane1_write_mask_n, lane0_write_mask_n} = msk;
    always #12.5 ref_clk = ~ref_clk;
    dbs_ctl_model u_ctl (.*);
    dbs_top DUT (.*);
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string n, logic [35:0] s, e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // one command at the next k strobe; returns on that edge
    task automatic cmd(logic r, w, logic [7:0] a, logic [35:0] d0, d1, logic [3:0] m0, m1);
        int i;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (!kn_rise && i < 16);
        if (!kn_rise) begin
            miscompares++;
            close_out();
        end
        read_sel_n <= r;
        write_sel_n <= w; // held at w through the k strobe
        {rd_addr, wr_addr, wr_data, msk} <= {a, a, d0, m0};
        repeat (2) @(posedge ref_clk);
        {read_sel_n, write_sel_n, wr_data, msk} <= {2'h3, d1, m1};
    endtask
    task automatic wr(logic [7:0] a, logic [35:0] d0, d1, logic [3:0] m0, m1);
        cmd(1'b1, 1'b0, a, d0, d1, m0, m1);
        repeat (4) @(posedge ref_clk); // keep writes a strobe apart
    endtask
    // read burst, write-select as given with all-ones data
    task automatic rd(logic w, logic [7:0] a, logic [35:0] e0, e1);
        cmd(1'b0, w, a, '1, '1, 4'h0, 4'h0);
        // beat registered on the 4th strobe (2nd in bypass), read one clock after it settles
        repeat (dll_on_n ? 9 : 5) @(posedge ref_clk);
        chk("beat0", rd_data, e0);
        repeat (2) @(posedge ref_clk);
        chk("beat1", rd_data, e1);
        chk("oe", rd_data_oe, 1'b1);
        repeat (2) @(posedge ref_clk);
        chk("oe_idle", rd_data_oe, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        wr(8'h11, 36'h5_5555_5555, 36'h0, 4'h0, 4'h0);
        wr(8'h13, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
        rd(1'b1, 8'h10, 36'h9_8765_4321, 36'h5_5555_5555);
        wr(8'h13, '1, '1, 4'hb, 4'hf);
        rd(1'b1, 8'h13, 36'h1_2345_6789 | 36'h0_07fc_0000, 36'h9_8765_4321);
        wide_mode <= 1'b0;
        wr(8'h13, 36'h0, 36'h0, 4'h0, 4'h0);
        wide_mode <= 1'b1;
        rd(1'b1, 8'h12, 36'h0, 36'h1_27fd_6789 & 36'hf_fffc_0000);
        // second write on the adjacent strobe is dropped
        cmd(1'b1, 1'b0, 8'h13, 36'h1, 36'h2, 4'h0, 4'h0);
        cmd(1'b1, 1'b0, 8'h13, '1, '1, 4'h0, 4'h0);
        repeat (4) @(posedge ref_clk);
        rd(1'b0, 8'h13, 36'h1, 36'h2);
        cmd(1'b0, 1'b1, 8'h13, 36'h0, 36'h0, 4'hf, 4'hf);
        cmd(1'b0, 1'b1, 8'h10, 36'h0, 36'h0, 4'hf, 4'hf);
        repeat (9) @(posedge ref_clk);
        chk("oe_drop", rd_data_oe, 1'b0);
        run <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk("hold", rd_data, 36'h2);
        run <= 1'b1;
        dll_on_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(1'b1, 8'h13, 36'h1, 36'h2);
        close_out();
    end
endmodule
bind dbs_top dbs_sva u_sva (.*);
